// ### bench/ldg_emitter_model.sv
// Purpose: Emitter and supply switch as seen from the drive pin
// Assumes: The guard samples the pin on core_clk
// Notes:   Pin faults are commanded by the bench
`timescale 1ns/10ps
module ldg_emitter_model (
    // Guard side
    input  wire logic test_ground_en,
    // Fault commands
    input  wire logic short_ground,
    input  wire logic short_supply,
    // Sensed level
    output logic      pin_grounded
);
    // A supply short outweighs the internal test ground path
    assign pin_grounded = !short_supply && (short_ground || test_ground_en);
endmodule // ldg_emitter_model

// ### bench/ldg_guard_properties.sv
// Purpose: Port assertions for the fault guard
// Assumes: One clock, rst_n async low
// Notes:   Calibration state is tracked from writes
`timescale 1ns/10ps
module ldg_guard_chk
    import ldg_pkg::*;
(
    // Watched ports
    input wire logic         core_clk,
    input wire logic         rst_n,
    input wire ldg_reg_req_s reg_req,
    input wire logic         pin_grounded,
    input wire logic         drive_on,
    input wire logic [7:0]   drive_level,
    input wire logic         test_ground_en,
    input wire logic         supply_switch_disable,
    input wire logic         fault_latched
);
    logic cal_r;
    wire  sd = supply_switch_disable;
    always_ff @(posedge core_clk or negedge rst_n)
        if (!rst_n) cal_r <= 1'b0;
        else if (reg_req.wr && reg_req.addr == OFS_BEAM_CFG)
            cal_r <= reg_req.wdata[CAL_MSB:CAL_LSB] == CAL_ENABLE;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_fault_cuts: assert property (
        pin_grounded && !test_ground_en && !sd
        |=> fault_latched && sd && !drive_on) else $error("fault not cut");
    a_fault_holds: assert property (
        fault_latched |=> fault_latched && sd && !drive_on)
        else $error("fault not held");
    a_test_dark: assert property (
        test_ground_en |-> sd && !drive_on) else $error("test not dark");
    a_test_span: assert property (
        $rose(test_ground_en) |-> ##50 test_ground_en ##1 !test_ground_en)
        else $error("test span wrong");
    a_switch_cause: assert property (
        $rose(sd) |-> test_ground_en || fault_latched)
        else $error("switch off without cause");
    a_pulse_gap: assert property (
        $fell(drive_on) && !cal_r && !sd |-> !drive_on [*8])
        else $error("pulse gap short");
    a_cal_steady: assert property (
        cal_r && $past(cal_r, 2) && !sd && !$past(sd, 2) |-> drive_on)
        else $error("calibration drive dropped");
    a_level_copy: assert property (
        reg_req.wr && reg_req.addr == OFS_CUR_CODE
        |=> ##1 drive_level == $past(reg_req.wdata, 2))
        else $error("drive level not copied");
endmodule // ldg_guard_chk
bind ldg_guard ldg_guard_chk ldg_guard_chk_inst (.core_clk(core_clk),
    .rst_n(rst_n), .reg_req(reg_req), .pin_grounded(pin_grounded),
    .drive_on(drive_on), .drive_level(drive_level),
    .test_ground_en(test_ground_en),
    .supply_switch_disable(supply_switch_disable),
    .fault_latched(fault_latched));

// ### bench/ldg_guard_tb.sv
// Purpose: Directed bench for the fault guard
// Assumes: Register tasks play the firmware
// Notes:   Self-test runs at its full period
`timescale 1ns/10ps
module ldg_guard_tb;
    import ldg_pkg::*;
    logic         clk = 0, rst_n = 0, sg = 0, ss = 0;
    ldg_reg_req_s rq = '0;
    logic [7:0]   rdat, lvl;
    logic         pin, on, hr, bm, tg, sd, flt, ok;
    int           bad_count = 0, comparisons = 0, n;
    always #4 clk = ~clk;
    ldg_guard ldg_guard_inst (.core_clk(clk), .rst_n(rst_n),
        .reg_req(rq), .reg_rdata(rdat), .pin_grounded(pin),
        .drive_on(on), .drive_level(lvl), .high_range(hr),
        .bin_match(bm), .test_ground_en(tg), .supply_switch_disable(sd),
        .fault_latched(flt), .settings_consistent(ok));
    ldg_emitter_model ldg_emitter_model_inst (.test_ground_en(tg),
        .short_ground(sg), .short_supply(ss), .pin_grounded(pin));
    task automatic chk(input logic [7:0] got, exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, d);
        rq = '{1'b1, a, d};
        cyc(1);
        rq.wr = 0;
        cyc(1);
    endtask
    task automatic rd(input logic [7:0] a, e);
        rq.addr = a;
        cyc(2);
        chk(rdat, e);
    endtask
    task automatic reset();
        rst_n = 0;
        cyc(12);
        rst_n = 1;
        cyc(1);
    endtask
    task automatic count_on(input int k);
        n = 0;
        repeat (k) begin
            cyc(1);
            n += int'(on === 1'b1);
        end
    endtask
    task automatic wait_tg();
        for (int i = 0; i < 3000 && tg !== 1'b1; i++) cyc(1);
        chk({5'h0, tg, sd, on}, 8'h06);
        cyc(60);
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        logic [7:0] o[5] = '{OFS_BEAM_CFG, OFS_CUR_CODE, OFS_CUR_CODE_INV,
                             OFS_BEAM_CFG_INV, 8'h1b};
        logic [7:0] v[5] = '{8'ha0, 8'h3c, 8'hc3, 8'h5f, 8'h77};
        reset();
        foreach (o[i]) wr(o[i], v[i]);
        foreach (o[i]) rd(o[i], i < 4 ? v[i] : 8'h00);
        chk({4'h0, hr, bm, ok, sd}, 8'h0e);
        chk(lvl, 8'h3c);
        $display("registers end");
        count_on(250);
        chk(n[7:0], 8'h32);
        $display("pulse end");
        wr(OFS_BEAM_CFG, 8'hae);
        wr(OFS_BEAM_CFG_INV, 8'h51);
        count_on(200);
        chk(n[7:0], 8'hc8);
        wait_tg();
        chk({5'h0, flt, sd, on}, 8'h01);
        $display("calibration and self-test end");
        ss = 1;
        wait_tg();
        chk({5'h0, flt, sd, on}, 8'h06);
        ss = 0;
        reset();
        sg = 1;
        cyc(2);
        chk({5'h0, flt, sd, on}, 8'h06);
        sg = 0;
        cyc(20);
        chk({5'h0, flt, sd, on}, 8'h06);
        reset();
        chk({6'h0, flt, sd}, 8'h00);
        wr(OFS_CUR_CODE_INV, 8'h12);
        chk({7'h0, ok}, 8'h00);
        $display("faults end");
        final_report();
    end
    initial begin
        #100000;
        bad_count++;
        final_report();
    end
endmodule // ldg_guard_tb

// ### hdl/ldg_guard.sv
// Purpose: Laser emitter drive with pulsed/continuous modes and fault guard
// Assumes: Register writes and drive pin sense are synchronous to core_clk
// Notes:   A fault latches until reset; firmware reloads settings after reset
`timescale 1ns/10ps
module ldg_guard
    import ldg_pkg::*;
(
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    // Register port
    input  wire ldg_reg_req_s reg_req,
    output logic [7:0]        reg_rdata,
    // Emitter drive
    input  wire logic         pin_grounded,
    output logic              drive_on,
    output logic [7:0]        drive_level,
    output logic              high_range,
    output logic              bin_match,
    output logic              test_ground_en,
    output logic              supply_switch_disable,
    // Status
    output logic              fault_latched,
    output logic              settings_consistent
);

    // ========================================================
    // Registers
    logic [7:0]  beam_cfg_r;
    logic [7:0]  beam_cfg_inv_r;
    logic [7:0]  cur_code_r;
    logic [7:0]  cur_code_inv_r;
    logic [7:0]  rdata_nxt;
    logic [15:0] period_cnt_r;
    logic [15:0] test_cnt_r;
    logic [15:0] settle_cnt_r;
    ldg_state_e  state_r, state_nxt;

    wire wr_beam    = reg_req.wr && reg_req.addr == OFS_BEAM_CFG;
    wire wr_cur     = reg_req.wr && reg_req.addr == OFS_CUR_CODE;
    wire wr_cur_inv = reg_req.wr && reg_req.addr == OFS_CUR_CODE_INV;
    wire wr_beam_inv = reg_req.wr && reg_req.addr == OFS_BEAM_CFG_INV;

    // ========================================================
    // Register storage, one bank per offset

    // Beam config: range, bin match and calibration fields
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            beam_cfg_r <= BEAM_RST;
        end else if (wr_beam) begin
            beam_cfg_r <= reg_req.wdata;
        end
    end

    // Beam config complement, kept by firmware
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            beam_cfg_inv_r <= BEAM_INV_RST;
        end else if (wr_beam_inv) begin
            beam_cfg_inv_r <= reg_req.wdata;
        end
    end

    // Drive current code
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cur_code_r <= CUR_RST;
        end else if (wr_cur) begin
            cur_code_r <= reg_req.wdata;
        end
    end

    // Drive current code complement, kept by firmware
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cur_code_inv_r <= CUR_INV_RST;
        end else if (wr_cur_inv) begin
            cur_code_inv_r <= reg_req.wdata;
        end
    end

    // Read decode
    always_comb begin
        if (reg_req.addr == OFS_BEAM_CFG) begin
            rdata_nxt = beam_cfg_r;
        end else if (reg_req.addr == OFS_BEAM_CFG_INV) begin
            rdata_nxt = beam_cfg_inv_r;
        end else if (reg_req.addr == OFS_CUR_CODE) begin
            rdata_nxt = cur_code_r;
        end else if (reg_req.addr == OFS_CUR_CODE_INV) begin
            rdata_nxt = cur_code_inv_r;
        end else begin
            rdata_nxt = 8'h00;
        end
    end

    // ========================================================
    // Setting checks
    wire cal_en   = beam_cfg_r[CAL_MSB:CAL_LSB] == CAL_ENABLE;
    wire cal_pair = (beam_cfg_r[CAL_MSB:CAL_LSB]
                    ^ beam_cfg_inv_r[CAL_MSB:CAL_LSB]) == 3'h7;
    wire rng_pair = beam_cfg_r[RANGE_BIT] ^ beam_cfg_inv_r[RANGE_BIT];
    wire mat_pair = beam_cfg_r[MATCH_BIT] ^ beam_cfg_inv_r[MATCH_BIT];
    wire cur_pair = (cur_code_r ^ cur_code_inv_r) == 8'hff;
    wire pairs_ok = rng_pair && mat_pair && cur_pair
                    && (!cal_en || cal_pair);

    // ========================================================
    // Pulse timing and self-test scheduler
    wire period_end = period_cnt_r == 16'(PULSE_PERIOD_CYC - 1);
    wire pulse_ph   = period_cnt_r < 16'(PULSE_ON_CYC);
    wire test_due   = test_cnt_r == 16'(TEST_PERIOD_CYC - 1);
    wire settled    = settle_cnt_r == 16'(TEST_SETTLE_CYC - 1);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN: begin
                if (pin_grounded) begin
                    state_nxt = ST_FAULT;
                end else if (test_due) begin
                    state_nxt = ST_TEST;
                end
            end
            ST_TEST: begin
                // Pin is pulled low on purpose here, so it is not judged
                if (settled) begin
                    state_nxt = ST_CHECK;
                end
            end
            ST_CHECK: begin
                // No ground seen means the detector or pin is broken
                if (pin_grounded) begin
                    state_nxt = ST_RUN;
                end else begin
                    state_nxt = ST_FAULT;
                end
            end
            ST_FAULT: begin
                state_nxt = ST_FAULT;
            end
            default: begin
                state_nxt = ST_FAULT;
            end
        endcase
    end

    // Counter next values
    wire [15:0] period_cnt_nxt = period_end ? 16'h0000
                                 : period_cnt_r + 16'h0001;
    wire [15:0] test_cnt_nxt   = (state_r != ST_RUN || test_due) ? 16'h0000
                                 : test_cnt_r + 16'h0001;
    wire [15:0] settle_cnt_nxt = (state_r == ST_TEST)
                                 ? settle_cnt_r + 16'h0001 : 16'h0000;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            period_cnt_r <= 16'h0000;
        end else begin
            period_cnt_r <= period_cnt_nxt;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            test_cnt_r <= 16'h0000;
        end else begin
            test_cnt_r <= test_cnt_nxt;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            settle_cnt_r <= 16'h0000;
        end else begin
            settle_cnt_r <= settle_cnt_nxt;
        end
    end

    // ========================================================
    // Output next values
    wire run_nxt        = state_nxt == ST_RUN;
    wire fault_nxt      = state_nxt == ST_FAULT;
    wire test_nxt       = state_nxt == ST_TEST || state_nxt == ST_CHECK;
    wire drive_on_nxt   = run_nxt && (cal_en || pulse_ph);
    wire switch_off_nxt = fault_nxt || test_nxt;

    // ========================================================
    // Register read output
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= rdata_nxt;
        end
    end

    // ========================================================
    // Drive outputs
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            drive_on <= 1'b0;
        end else begin
            drive_on <= drive_on_nxt;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            drive_level <= 8'h00;
        end else begin
            drive_level <= cur_code_r;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            high_range <= 1'b0;
        end else begin
            high_range <= beam_cfg_r[RANGE_BIT];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bin_match <= 1'b0;
        end else begin
            bin_match <= beam_cfg_r[MATCH_BIT];
        end
    end

    // ========================================================
    // Fault guard and self-test outputs
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            test_ground_en <= 1'b0;
        end else begin
            test_ground_en <= test_nxt;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            supply_switch_disable <= 1'b0;
        end else begin
            supply_switch_disable <= switch_off_nxt;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_latched <= 1'b0;
        end else begin
            fault_latched <= fault_nxt;
        end
    end

    // ========================================================
    // Status
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            settings_consistent <= 1'b0;
        end else begin
            settings_consistent <= pairs_ok;
        end
    end

endmodule // ldg_guard

// ### hdl/ldg_pkg.sv
// Purpose: Shared constants and types for the laser drive fault guard
// Assumes: Registers are 8 bits wide, reached by a plain write/read port
// Notes:   Self-test timing counts are derived from the 125 MHz core clock
package ldg_pkg;

    // ========================================================
    // Register offsets
    localparam logic [7:0] OFS_BEAM_CFG     = 8'h1a;
    localparam logic [7:0] OFS_CUR_CODE     = 8'h1c;
    localparam logic [7:0] OFS_CUR_CODE_INV = 8'h1d;
    localparam logic [7:0] OFS_BEAM_CFG_INV = 8'h1f;

    // ========================================================
    // Field positions and values
    localparam int         RANGE_BIT   = 7;
    localparam int         MATCH_BIT   = 5;
    localparam int         CAL_LSB     = 1;
    localparam int         CAL_MSB     = 3;
    localparam logic [2:0] CAL_ENABLE  = 3'h7;
    localparam logic [7:0] BEAM_RST    = 8'h00;
    localparam logic [7:0] BEAM_INV_RST = 8'hff;
    localparam logic [7:0] CUR_RST     = 8'h00;
    localparam logic [7:0] CUR_INV_RST = 8'hff;

    // ========================================================
    // Timing
    localparam int CLK_MHZ         = 125;
    localparam int PULSE_PERIOD_NS = 1000;
    localparam int PULSE_ON_NS     = 200;
    localparam int TEST_PERIOD_US  = 20;
    localparam int TEST_SETTLE_NS  = 400;
    localparam int PULSE_PERIOD_CYC = PULSE_PERIOD_NS * CLK_MHZ / 1000;
    localparam int PULSE_ON_CYC     = PULSE_ON_NS * CLK_MHZ / 1000;
    localparam int TEST_PERIOD_CYC  = TEST_PERIOD_US * CLK_MHZ;
    localparam int TEST_SETTLE_CYC  = (TEST_SETTLE_NS * CLK_MHZ + 999) / 1000;

    // ========================================================
    // Types
    typedef enum logic [1:0] {ST_RUN, ST_TEST, ST_CHECK, ST_FAULT} ldg_state_e;

    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ldg_reg_req_s;

endpackage
